// ---- rtl/srsc_host.sv ----
`timescale 1ns/10ps
`default_nettype none

module srsc_host import srsc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // User command port
  input wire logic req,
  input wire logic [1:0] op,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic ready,
  output logic rd_valid,
  output logic [DATA_W-1:0] rdata,
  // Memory pins
  output logic cycle_strobe_n,
  output logic select_first_n,
  output logic select_second_n,
  output logic write_strobe_n,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_in
);

  srsc_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [1:0] op_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] data_sync;

  // Memory data pins are not on our clock
  // Only the second stage is read; the first may still be settling
  srsc_sync2 #(.W(DATA_W)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(data_in),
    .sync_out(data_sync)
  );

  wire take = (st_q == ST_IDLE) && req;
  wire [1:0] op_d = take ? op : op_q;
  wire is_write = (op_d == OP_WRITE);
  wire is_rmw = (op_q == OP_RMW);
  wire cnt_zero = (cnt_q == '0);
  wire [CNT_W-1:0] cnt_dec = cnt_zero ? cnt_q : cnt_q - CNT_W'(1);
  // Last cycle of the read wait: the synchronised word is taken here
  wire capture = (st_q == ST_RD_ACCESS) && cnt_zero;

  // Next-state view shared by the pin decodes
  wire nx_idle = (st_d == ST_IDLE);
  wire nx_addr = (st_d == ST_ADDR);
  wire nx_rd = (st_d == ST_RD_ACCESS);
  wire nx_dis = (st_d == ST_WR_DISABLE);
  wire nx_data = (st_d == ST_WR_DATA);
  wire nx_latch = (st_d == ST_WR_LATCH);
  wire nx_pulse = (st_d == ST_WR_PULSE);
  wire nx_end = (st_d == ST_WR_END);

  // Pin decode from the next state so each pin is a flip-flop
  wire strobe_low_d = nx_rd || nx_dis || nx_data || nx_latch || nx_pulse || nx_end;
  // Both selects move together; released first so the write ends on a select rise
  wire sel_low_d = nx_rd || nx_dis || nx_data || nx_pulse;
  // Plain writes drop the write strobe before the selects so outputs never turn on
  // Each write gets its own pulse; holding it low across a run of writes is allowed but unused
  wire we_low_d = (nx_addr && is_write) || nx_dis || nx_data
                  || nx_latch || nx_pulse || nx_end;
  // Drive only once the memory cannot be driving; hold one cycle past the ending edge
  wire oe_d = (nx_addr && is_write) || nx_data || nx_latch
              || nx_pulse || nx_end;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_dec;
    case (st_q)
      ST_IDLE: begin
        if (req) begin
          st_d = ST_ADDR;
          cnt_d = '0;
        end
      end
      ST_ADDR: begin
        if (op_q == OP_WRITE) begin
          st_d = ST_WR_LATCH;
          cnt_d = CNT_W'(ADDR_HOLD_CYC - 1);
        end else begin
          st_d = ST_RD_ACCESS;
          // One spare cycle: the word is only sure at the access edge itself,
          // and a sample taken on that very edge would race the memory
          cnt_d = CNT_W'(ACCESS_CYC + SYNC_CYC);
        end
      end
      ST_RD_ACCESS: begin
        if (cnt_zero && is_rmw) begin
          st_d = ST_WR_DISABLE;
          cnt_d = CNT_W'(DISABLE_CYC - 1);
        end else if (cnt_zero) begin
          st_d = ST_FINISH;
          cnt_d = CNT_W'(RECOVER_CYC - 1);
        end
      end
      ST_WR_DISABLE: begin
        if (cnt_zero) begin
          st_d = ST_WR_DATA;
          cnt_d = CNT_W'(RMW_DATA_CYC - 1);
        end
      end
      ST_WR_LATCH: begin
        if (cnt_zero) begin
          st_d = ST_WR_PULSE;
          cnt_d = CNT_W'(PULSE_CYC - 1);
        end
      end
      ST_WR_DATA, ST_WR_PULSE: begin
        if (cnt_zero) begin
          st_d = ST_WR_END;
          cnt_d = CNT_W'(DATA_HOLD_CYC - 1);
        end
      end
      ST_WR_END: begin
        if (cnt_zero) begin
          st_d = ST_FINISH;
          cnt_d = CNT_W'(RECOVER_CYC - 1);
        end
      end
      ST_FINISH: begin
        if (cnt_zero) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      op_q <= OP_READ;
      wdata_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      op_q <= op_d;
      if (take) begin
        wdata_q <= wdata;
      end
    end
  end

  // Address register stays put for the whole cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_addr <= '0;
    end else if (take) begin
      mem_addr <= addr;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cycle_strobe_n <= PIN_IDLE;
      select_first_n <= PIN_IDLE;
      select_second_n <= PIN_IDLE;
      write_strobe_n <= PIN_IDLE;
    end else begin
      cycle_strobe_n <= !strobe_low_d;
      select_first_n <= !sel_low_d;
      select_second_n <= !sel_low_d;
      write_strobe_n <= !we_low_d;
    end
  end

  // Data pins; the word is loaded on the take edge so it leads the write pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_oe <= 1'b0;
      data_out <= '0;
    end else begin
      data_oe <= oe_d;
      data_out <= take ? wdata : wdata_q;
    end
  end

  // Sampled before the strobe rise, so the output latch holds the same word
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
      rd_valid <= 1'b0;
      ready <= 1'b1;
    end else begin
      rd_valid <= capture;
      if (capture) begin
        rdata <= data_sync;
      end
      // Ready follows the idle state, so no request lands during recovery
      ready <= nx_idle;
    end
  end

endmodule // srsc_host

`default_nettype wire

// ---- rtl/srsc_pkg.sv ----
package srsc_pkg;

  // Array shape of the memory on the far side
  localparam int ADDR_W = 8;
  localparam int DATA_W = 4;

  // Clock rate
  localparam int CLK_PERIOD_PS = 25000;

  // Memory timing figures in ns
  localparam int STROBE_ACCESS_DELAY_NS = 300;
  localparam int ADDR_HOLD_NS = 50;
  localparam int STROBE_HIGH_NS = 100;
  localparam int SELECT_OUTPUT_FLOAT_DELAY_NS = 150;
  localparam int WRITE_DATA_SETUP_NS = 150;
  localparam int WRITE_DATA_HOLD_NS = 0;
  localparam int WRITE_OUTPUT_DISABLE_DELAY_NS = 30;
  localparam int MIN_WRITE_PULSE_NS = 180;

  // Least times rounded up to whole cycles, at least one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int SYNC_CYC = 2;
  localparam int ACCESS_CYC = cyc_up(STROBE_ACCESS_DELAY_NS);
  localparam int ADDR_HOLD_CYC = cyc_up(ADDR_HOLD_NS);
  localparam int RECOVER_CYC = max2(cyc_up(STROBE_HIGH_NS), cyc_up(SELECT_OUTPUT_FLOAT_DELAY_NS));
  localparam int DATA_SETUP_CYC = cyc_up(WRITE_DATA_SETUP_NS);
  localparam int DATA_HOLD_CYC = cyc_up(WRITE_DATA_HOLD_NS);
  localparam int DISABLE_CYC = cyc_up(WRITE_OUTPUT_DISABLE_DELAY_NS);
  localparam int PULSE_CYC = max2(cyc_up(MIN_WRITE_PULSE_NS), DATA_SETUP_CYC);
  localparam int RMW_DATA_CYC = max2(DATA_SETUP_CYC, cyc_up(MIN_WRITE_PULSE_NS) - DISABLE_CYC);

  localparam int CNT_W = 5;

  // Command codes
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_RMW = 2'h2;

  // Pin levels out of reset: strobes and selects idle high
  localparam logic PIN_IDLE = 1'h1;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_RD_ACCESS,
    ST_WR_DISABLE,
    ST_WR_DATA,
    ST_WR_LATCH,
    ST_WR_PULSE,
    ST_WR_END,
    ST_FINISH
  } srsc_state_t;

endpackage

// ---- rtl/srsc_sync2.sv ----
`timescale 1ns/10ps
`default_nettype none

module srsc_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Asynchronous input and synchronised copy
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // srsc_sync2

`default_nettype wire

// ---- verification/srsc_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module srsc_assertions import srsc_pkg::*; (
  // Clock
  input wire logic clk,
  input wire logic resetn,
  // Pins
  input wire logic cycle_strobe_n,
  input wire logic select_first_n,
  input wire logic select_second_n,
  input wire logic write_strobe_n,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire sel = !select_first_n && !select_second_n;
  property p_adr; !cycle_strobe_n |-> $stable(mem_addr); endproperty
  a_adr: assert property (p_adr) else $error("addr moved");
  property p_rd; $fell(cycle_strobe_n) && write_strobe_n |-> ##11 (!cycle_strobe_n && sel && write_strobe_n); endproperty
  a_rd: assert property (p_rd) else $error("read cut short");
  property p_su; $rose(select_first_n) && !write_strobe_n |-> data_oe && $past(data_oe, 6) &&
    data_out == $past(data_out, 6); endproperty
  a_su: assert property (p_su) else $error("data setup short");
  property p_bus; data_oe |-> !sel || !write_strobe_n; endproperty
  a_bus: assert property (p_bus) else $error("bus clash");
  property p_dis; $fell(write_strobe_n) && sel |-> !data_oe [*2]; endproperty
  a_dis: assert property (p_dis) else $error("driven too soon");
  property p_ew; $fell(cycle_strobe_n) && !write_strobe_n |-> !sel; endproperty
  a_ew: assert property (p_ew) else $error("early write selected");
  property p_wp; $fell(write_strobe_n) && !sel |-> !write_strobe_n [*8]; endproperty
  a_wp: assert property (p_wp) else $error("write pulse short");
  property p_end; $rose(write_strobe_n) |-> select_first_n && select_second_n; endproperty
  a_end: assert property (p_end) else $error("write ended by write strobe");
  c_rd: cover property ($fell(cycle_strobe_n) && write_strobe_n);
  c_wr: cover property ($fell(write_strobe_n) && !sel);
  c_rmw: cover property ($fell(write_strobe_n) && sel);
endmodule // srsc_assertions
`default_nettype wire

// ---- verification/srsc_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module srsc_mem_model import srsc_pkg::*; #(
  parameter int ACC_NS = STROBE_ACCESS_DELAY_NS
) (
  // Pins
  input wire logic cycle_strobe_n,
  input wire logic select_first_n,
  input wire logic select_second_n,
  input wire logic write_strobe_n,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  // Bus and clash flag
  output logic [DATA_W-1:0] data_in,
  output logic clash
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] q_q;
  logic [ADDR_W-1:0] a_q = '0;
  logic valid = 1'b0;
  realtime t_d = 0;
  wire sel = !select_first_n && !select_second_n;
  wire wr = sel && !cycle_strobe_n && !write_strobe_n;
  wire oe = sel && write_strobe_n;
  wire [DATA_W-1:0] q = cycle_strobe_n ? q_q : mem[a_q];
  // Floating bus shows the inverse so a mistimed sample cannot pass
  assign data_in = data_oe ? data_out : (oe && (valid || cycle_strobe_n)) ? q : ~q;
  initial begin
    clash = 1'b0;
    q_q = '0;
    foreach (mem[i]) mem[i] = '0;
  end
  always @* if (oe && data_oe) clash = 1'b1;
  always @(negedge cycle_strobe_n) begin
    a_q = mem_addr;
    valid = 1'b0;
    #(ACC_NS) valid = 1'b1;
  end
  always @(posedge cycle_strobe_n) q_q = mem[a_q];
  always @(data_out or data_oe) t_d = $realtime;
  // Short setup at the ending edge stores a wrong word
  always @(negedge wr) mem[a_q] = (data_oe && $realtime - t_d >= WRITE_DATA_SETUP_NS) ? data_out : ~data_out;
endmodule // srsc_mem_model
`default_nettype wire

// ---- verification/test_strobe_latched_sram_cycles.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_strobe_latched_sram_cycles import srsc_pkg::*; ;
  logic clk = 1'b0;
  logic resetn, req, ready, rd_valid, data_oe, clash;
  logic cycle_strobe_n, select_first_n, select_second_n, write_strobe_n;
  logic [1:0] op;
  logic [ADDR_W-1:0] addr, mem_addr;
  logic [DATA_W-1:0] wdata, rdata, data_out, data_in;
  int err_total = 0;
  int checks_done = 0;
  always #12.5 clk = ~clk;
  srsc_host u_srsc_host (.clk, .resetn, .req, .op, .addr, .wdata, .ready, .rd_valid, .rdata, .cycle_strobe_n,
    .select_first_n, .select_second_n, .write_strobe_n, .mem_addr, .data_out, .data_oe, .data_in);
  srsc_mem_model u_srsc_mem_model (.cycle_strobe_n, .select_first_n, .select_second_n, .write_strobe_n,
    .mem_addr, .data_out, .data_oe, .data_in, .clash);
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Reads must pulse rd_valid once with the stored word
  task automatic cmd(input logic [1:0] o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, e);
    int n;
    int got;
    got = 0;
    req = 1'b1;
    op = o;
    addr = a;
    wdata = d;
    for (n = 0; n < 60 && !(n > 2 && ready === 1'b1); n++) begin
      @(negedge clk);
      if (n == 0)
        req = 1'b0;
      if (rd_valid === 1'b1) begin
        got++;
        chk("rdata", 8'(e), 8'(rdata));
      end
    end
    chk("rd_valid", (o == OP_WRITE) ? 8'h0 : 8'h1, 8'(got));
    if (n == 60) begin
      err_total++;
      $display("[FAIL] ready expected 1 seen 0");
      give_verdict();
    end
  endtask
  task automatic t_write_read;
    cmd(OP_WRITE, 8'h00, 4'h9, 4'h0);
    cmd(OP_WRITE, 8'hff, 4'h6, 4'h0);
    cmd(OP_READ, 8'h00, 4'h0, 4'h9);
    cmd(OP_READ, 8'hff, 4'h0, 4'h6);
  endtask
  task automatic t_rmw;
    cmd(OP_RMW, 8'hff, 4'h3, 4'h6);
    cmd(OP_READ, 8'hff, 4'h0, 4'h3);
  endtask
  task automatic t_back;
    cmd(OP_WRITE, 8'h5a, 4'ha, 4'h0);
    cmd(2'h3, 8'h5a, 4'h0, 4'ha);
    cmd(OP_READ, 8'h00, 4'h0, 4'h9);
  endtask
  initial begin
    resetn = 1'b0;
    req = 1'b0;
    op = OP_READ;
    addr = '0;
    wdata = '0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    t_write_read();
    t_rmw();
    t_back();
    chk("clash", 8'h0, 8'(clash));
    give_verdict();
  end
endmodule // test_strobe_latched_sram_cycles
bind srsc_host srsc_assertions u_srsc_assertions (.clk, .resetn, .cycle_strobe_n, .select_first_n,
  .select_second_n, .write_strobe_n, .mem_addr, .data_out, .data_oe);
`default_nettype wire
